//--- logic/hsc_ctrl.sv
// Holdover and sync control word with its hold and start gating logic
`timescale 1ns/1ps
`default_nettype none
module hsc_ctrl
	import hsc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              word_valid,
	input  wire logic [WORD_W-1:0] word_data,
	input  wire hsc_status_t       status,
	input  wire logic              start_req,
	output logic [WORD_W-1:0]      word_readback,
	output hsc_fields_t            fields,
	output logic                   cp_three_state,
	output logic                   hold_one_active,
	output logic                   hold_two_active,
	output logic                   hold_one_inverted,
	output logic                   ref_div_preset_n,
	output logic                   hold_int,
	output logic                   reset_int,
	output logic [1:0]             lock_window_hi,
	output logic                   divider_sync_bypass,
	output logic                   sync_enable,
	output logic                   start_out
);
	// ==========================================================
	// Configuration word
	logic [WORD_W-1:0] word_q, word_d;
	hsc_fields_t       f;
	always_comb begin
		word_d = word_q;
		if (word_valid && word_data[ADDR_W-1:0] == ADDR_THIS_WORD) begin
			word_d = word_data;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			word_q <= RESET_WORD;
		end else begin
			word_q <= word_d;
		end
	end
	assign f = word_q[POS_OUT_BIAS+1:POS_HOLD1_EN];
	assign fields = f;
	assign word_readback = word_q;
	assign lock_window_hi = f.lock_window_hi;

	// ==========================================================
	// Hold logic
	logic             hold_raw;
	logic             hold1_q, hold1_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, react_limit;
	logic             lock_q;
	always_comb begin
		case (f.hold_reactivate_count)
			2'b00:   react_limit = REACT_64;
			2'b01:   react_limit = REACT_128;
			2'b10:   react_limit = REACT_256;
			default: react_limit = REACT_512;
		endcase
		hold_raw = f.hold_trigger_mode | status.pll_locked;
		hold1_d = hold1_q;
		cnt_d = cnt_q;
		if (!f.freq_holdover_one_en) begin
			hold1_d = 1'b0;
			cnt_d = '0;
		end else if (hold_raw) begin
			if (hold1_q || cnt_q == '0) begin
				hold1_d = 1'b1;
				cnt_d = '0;
			end else if (cnt_q >= react_limit) begin
				hold1_d = 1'b1;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 10'h001;
			end
		end else begin
			hold1_d = 1'b0;
			if (hold1_q) begin
				cnt_d = 10'h001;
			end else if (cnt_q != '0 && cnt_q < react_limit) begin
				cnt_d = cnt_q + 10'h001;
			end
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			hold1_q <= 1'b0;
			cnt_q <= '0;
			lock_q <= 1'b0;
		end else begin
			hold1_q <= hold1_d;
			cnt_q <= cnt_d;
			lock_q <= lock_q | status.pll_locked;
		end
	end
	assign hold_one_active = hold1_q;
	assign hold_one_inverted = ~hold1_q;
	assign hold_two_active = f.freq_holdover_two_en & hold_raw;
	assign cp_three_state = f.cp_hold | status.hold_pin;
	assign ref_div_preset_n = f.ref_divider_preset_sel | hold_one_inverted;
	assign hold_int = f.internal_ctrl_polarity ?
		(f.cp_hold | status.hold_pin) : ~(f.cp_hold | status.hold_pin);
	assign reset_int = f.internal_ctrl_polarity ? status.reset_pin
		: ~status.reset_pin;
	assign divider_sync_bypass = status.diagnostic_mode_bit
		& f.divider_sync_disable;

	// ==========================================================
	// Start gating
	logic start_q, start_d;
	always_comb begin
		sync_enable = (f.clock_detect_bypass | status.oscillator_clock_present
			| status.aux_clock_present)
			& (f.first_lock_bypass | lock_q)
			& (~f.low_freq_gate_enable | status.feedback_fast);
		start_d = sync_enable & start_req;
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start_d;
		end
	end
	assign start_out = f.start_bypass ? (sync_enable & start_req)
		: start_q;

	// ==========================================================
	// Assertions
	word_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
		word_valid && word_data[3:0] == 4'h9 |=> word_q == $past(word_data))
		else $error("word not loaded");
	word_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!(word_valid && word_data[3:0] == 4'h9) |=> $stable(word_q))
		else $error("word changed without select");
	hold_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!f.freq_holdover_one_en |=> !hold1_q)
		else $error("hold one active while disabled");
	hold_two_a: assert property (@(posedge core_clk) disable iff (!nrst)
		hold_two_active == (f.freq_holdover_two_en && (f.hold_trigger_mode || status.pll_locked)))
		else $error("hold two wrong");
	cp_state_a: assert property (@(posedge core_clk) disable iff (!nrst)
		word_q[6] |-> cp_three_state)
		else $error("pump not three-stated");
	react_min_a: assert property (@(posedge core_clk) disable iff (!nrst)
		hold1_q ##1 !hold1_q ##1 (f.hold_reactivate_count == 2'b00)[*8] |-> !hold1_q)
		else $error("hold one reactivated early");
	polarity_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!word_q[12] |-> reset_int == !status.reset_pin)
		else $error("reset not inverted");
	divsync_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!status.diagnostic_mode_bit |-> !divider_sync_bypass)
		else $error("bypass outside diagnostic mode");
	start_sync_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!f.start_bypass && $past(!f.start_bypass) |-> start_out == $past(start_d))
		else $error("start not synchronised");
	lock_wait_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!f.first_lock_bypass && !lock_q |-> !sync_enable)
		else $error("sync before first lock");
	low_freq_a: assert property (@(posedge core_clk) disable iff (!nrst)
		f.low_freq_gate_enable && !status.feedback_fast |-> !sync_enable)
		else $error("sync below frequency");
	preset_a: assert property (@(posedge core_clk) disable iff (!nrst)
		word_q[18] |-> ref_div_preset_n)
		else $error("preset while deselected");
	load_c: cover property (@(posedge core_clk) disable iff (!nrst)
		word_valid && word_data[3:0] == 4'h9);
	react_c: cover property (@(posedge core_clk) disable iff (!nrst)
		!hold1_q ##1 hold1_q && cnt_q == '0 && f.freq_holdover_one_en);
	start_c: cover property (@(posedge core_clk) disable iff (!nrst) start_out);
endmodule
`default_nettype wire

//--- logic/hsc_pkg.sv
// Package: field layout and constants of the holdover and sync control word
package hsc_pkg;
	localparam int        WORD_W          = 32;
	localparam int        ADDR_W          = 4;
	localparam logic [3:0] ADDR_THIS_WORD = 4'h9;
	localparam logic [WORD_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam int POS_HOLD1_EN   = 4;
	localparam int POS_HOLD2_EN   = 5;
	localparam int POS_CP_HOLD    = 6;
	localparam int POS_TRIGGER    = 7;
	localparam int POS_COUNT_LO   = 8;
	localparam int POS_COUNT_HI   = 9;
	localparam int POS_LOCKW2     = 10;
	localparam int POS_LOCKW3     = 11;
	localparam int POS_POLARITY   = 12;
	localparam int POS_DIVSYNC    = 13;
	localparam int POS_START_BP   = 14;
	localparam int POS_CLKDET_BP  = 15;
	localparam int POS_LOCK_BP    = 16;
	localparam int POS_LOWF_EN    = 17;
	localparam int POS_PRESET_SEL = 18;
	localparam int POS_FB_BIAS    = 19;
	localparam int POS_OUT_BIAS   = 21;
	localparam int CNT_W          = 10;
	localparam logic [CNT_W-1:0] REACT_64  = 10'h040;
	localparam logic [CNT_W-1:0] REACT_128 = 10'h080;
	localparam logic [CNT_W-1:0] REACT_256 = 10'h100;
	localparam logic [CNT_W-1:0] REACT_512 = 10'h200;

	typedef struct packed {
		logic [1:0] output_divider_bias;
		logic [1:0] feedback_divider_bias;
		logic       ref_divider_preset_sel;
		logic       low_freq_gate_enable;
		logic       first_lock_bypass;
		logic       clock_detect_bypass;
		logic       start_bypass;
		logic       divider_sync_disable;
		logic       internal_ctrl_polarity;
		logic [1:0] lock_window_hi;
		logic [1:0] hold_reactivate_count;
		logic       hold_trigger_mode;
		logic       cp_hold;
		logic       freq_holdover_two_en;
		logic       freq_holdover_one_en;
	} hsc_fields_t;

	typedef struct packed {
		logic oscillator_clock_present;
		logic aux_clock_present;
		logic pll_locked;
		logic feedback_fast;
		logic diagnostic_mode_bit;
		logic hold_pin;
		logic reset_pin;
	} hsc_status_t;
endpackage

//--- tb/hsc_host.sv
// Parallel word bus host model that writes configuration words
`timescale 1ns/1ps
`default_nettype none
module hsc_host
	import hsc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              go,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [WORD_W-1:0] word_in,
	output logic                   word_valid,
	output logic [WORD_W-1:0]      word_data
);
	logic [WORD_W-1:0] w;
	// ==========
	// Word shaping
	always_comb begin
		w = word_in;
		w[ADDR_W-1:0] = addr;
		if (w[20:19] == 2'b11) w[20] = 1'b0;
		if (w[22:21] == 2'b11) w[22] = 1'b0;
	end
	// ==========
	// Bus drive, inverse of the previous bus value when idle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			word_valid <= 1'b0;
			word_data  <= '0;
		end else begin
			word_valid <= go;
			word_data  <= go ? w : ~word_data;
		end
	end
endmodule
`default_nettype wire

//--- tb/holdover_sync_control_word_bench.sv
// Self-checking bench of the holdover and sync control word
`timescale 1ns/1ps
`default_nettype none
module holdover_sync_control_word_bench
	import hsc_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        go = 1'b0;
	logic        start_req = 1'b0;
	logic [3:0]  addr = '0;
	logic [31:0] word_in = '0;
	hsc_status_t status = '0;
	logic [31:0] word_data, word_readback, cur = '0;
	logic        word_valid, cp_three_state, hold_one_active, hold_two_active;
	logic        hold_one_inverted, ref_div_preset_n, hold_int, reset_int;
	logic        divider_sync_bypass, sync_enable, start_out;
	logic [1:0]  lock_window_hi;
	logic        lock_seen = 1'b0, s_prev = 1'b0, e_sync;
	hsc_fields_t fields;
	logic [31:0] q[$];
	int          n_errors = 0, samples_checked = 0, cycles = 0, seed;
	// ==========
	// Instances
	hsc_host host (.core_clk(core_clk), .nrst(nrst), .go(go), .addr(addr),
		.word_in(word_in), .word_valid(word_valid), .word_data(word_data));
	hsc_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .word_valid(word_valid),
		.word_data(word_data), .status(status), .start_req(start_req),
		.word_readback(word_readback), .fields(fields),
		.cp_three_state(cp_three_state), .hold_one_active(hold_one_active),
		.hold_two_active(hold_two_active),
		.hold_one_inverted(hold_one_inverted),
		.ref_div_preset_n(ref_div_preset_n), .hold_int(hold_int),
		.reset_int(reset_int), .lock_window_hi(lock_window_hi),
		.divider_sync_bypass(divider_sync_bypass),
		.sync_enable(sync_enable), .start_out(start_out));
	always #4 core_clk = ~core_clk;
	// ==========
	// Checking
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors=%0d checked=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========
	// Notes of taken writes, timeout
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 3000) begin
			n_errors++;
			end_sim();
		end
		if (nrst && word_valid && word_data[3:0] == ADDR_THIS_WORD)
			q.push_back(word_data);
		if (nrst)
			lock_seen = lock_seen | status.pll_locked;
	end
	// ==========
	// Output watcher
	always @(negedge core_clk) begin
		if (nrst) begin
			if (q.size() > 0)
				cur = q.pop_front();
			chk(word_readback, cur);
			chk(fields, cur[22:4]);
			chk(lock_window_hi, cur[11:10]);
			chk(cp_three_state, cur[6] | status.hold_pin);
			chk(hold_two_active, cur[5] & (cur[7] | status.pll_locked));
			chk(hold_int, (cur[6] | status.hold_pin) == cur[12]);
			chk(reset_int, status.reset_pin == cur[12]);
			chk(divider_sync_bypass, status.diagnostic_mode_bit & cur[13]);
			chk(hold_one_inverted, hold_one_active == 1'b0);
			chk(ref_div_preset_n, cur[18] | hold_one_inverted);
			e_sync = (cur[15] | status.oscillator_clock_present
				| status.aux_clock_present) & (cur[16] | lock_seen)
				& (!cur[17] | status.feedback_fast);
			chk(sync_enable, e_sync);
			if (cur[14])
				chk(start_out, e_sync & start_req);
			else
				chk(start_out, s_prev);
			s_prev = e_sync & start_req;
		end
	end
	// ==========
	// Stimulus
	initial begin
		seed = $urandom(32'h2056);
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 400; i++) begin
			@(posedge core_clk);
			go        <= ($urandom % 4) != 0;
			addr      <= (($urandom % 6) == 0) ? 4'($urandom) : ADDR_THIS_WORD;
			word_in   <= $urandom;
			status    <= hsc_status_t'(7'($urandom));
			start_req <= 1'($urandom);
		end
		repeat (4) @(posedge core_clk);
		end_sim();
	end
endmodule
`default_nettype wire
